//--- src/io_ctrl_consts.vh
`ifndef IO_CTRL_CONSTS_VH
`define IO_CTRL_CONSTS_VH
// register indices (byte address = index * 4)
`define IDX_NB_CNTL 8'h01
`define IDX_MISC_12 8'h12
`define IDX_BRG13_CNTL 8'h1f
`define IDX_BRG_FIRST 8'h51
`define IDX_BRG_LAST 8'h63
`define IDX_PCIE_RID 8'h6a
`define IDX_FEATURE 8'h75
`define IDX_CLK_CFG 8'h8c
`define IDX_BRG_INT 8'h90
// field positions
`define BIT_ZERO_BE 8
`define BIT_EDGE_LEVEL 19
`define BIT_RID_GFX 16
`define BIT_RID_GPP 17
`define BIT_RID_PCIE 3
`define BIT_P2P_DIS 3
`define BIT_JTAG_EN 11
`define BIT_MCU_EN 12
`define BIT_P2P_MODE_LO 9
`define BIT_MST_GATE_DIS 13
`define BIT_SLV_GATE_DIS 14
`define BIT_AER_LO 13
`define AER_FIELD_ON 3'h4
// reset values
`define RST_FEATURE 32'h0000_1800
`define RST_CLK_CFG 32'h0000_6000
`define P2P_MODE_ALL 2'h2
`endif

//--- src/io_ctrl_feature_gating.v
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "io_ctrl_consts.vh"
// Operation
// - forward requester id to graphics bridges
// - forward requester id to port bridges
// - core requester id forwarding needs enable bit
// - debug access path enabled at reset
// - disabled debug path: drop, commit, ones
// - secure init clears debug enable
// - microcontroller path enabled at reset
// - disabled microcontroller path: drop, commit, ones
// - secure init clears microcontroller enable
// - pass zero byte enables upstream when set
// - return original packet when error reporting on
// - southbridge target only in modes one, two
// - only memory writes carried peer to peer
// - per bridge peer path disable bits
// - only master and slave branches gated
// - gate disable bits for master, slave
// - remap only with southbridge interrupt routing
// - per bridge interrupt rotation
// - alternate group lands on e to h
// - mode two forwards memory writes from enabled sources to host
module io_ctrl_feature_gating #(
  parameter NUM_BRG = 11
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire secure_init,
  input wire dbg_req,
  input wire dbg_write,
  input wire dbg_posted,
  output reg dbg_accept,
  output reg dbg_complete,
  output reg dbg_rd_ones,
  input wire mcu_req,
  input wire mcu_write,
  input wire mcu_posted,
  output reg mcu_accept,
  output reg mcu_complete,
  output reg mcu_rd_ones,
  input wire p2p_req,
  input wire p2p_src_sb,
  input wire [3:0] p2p_src_brg,
  input wire p2p_is_mem_wr,
  input wire p2p_hit,
  input wire p2p_tgt_sb,
  input wire [3:0] p2p_tgt_brg,
  output reg p2p_fwd_peer,
  output reg p2p_fwd_host,
  output reg p2p_drop,
  output reg p2p_fwd_rid,
  output reg pcie_rid_fwd_en,
  input wire [15:0] dma_be,
  output reg [15:0] host_be,
  input wire [2:0] err_core,
  input wire err_valid,
  output reg err_return,
  output reg edge_level_en,
  input wire mst_idle,
  input wire slv_idle,
  output reg master_branch_clk_en,
  output reg slave_branch_clk_en,
  input wire nb_irq_ctrl_dis,
  input wire [3:0] int_brg,
  input wire [3:0] int_in,
  output reg [7:0] int_out
);
  reg [31:0] nb_cntl_q;
  reg [31:0] misc12_q;
  reg [31:0] rid_q;
  reg [31:0] feat_q;
  reg [31:0] clk_q;
  reg [NUM_BRG-1:0] p2p_dis_q;
  reg [15:0] alt_interrupt_group_select_q;

  // bridge number to slot 0..10 (2-7,9-13), 4'hf if none
  function [3:0] brg_slot;
    input [3:0] b;
    begin
      if (b >= 4'h2 && b <= 4'h7) brg_slot = b - 4'h2;
      else if (b >= 4'h9 && b <= 4'hd) brg_slot = b - 4'h3;
      else brg_slot = 4'hf;
    end
  endfunction

  // rotation amount per bridge
  function [1:0] rot_amt;
    input [3:0] b;
    begin
      case (b)
        4'h5, 4'h9, 4'hd: rot_amt = 2'h1;
        4'h2, 4'h6, 4'ha: rot_amt = 2'h2;
        4'h3, 4'h7, 4'hb: rot_amt = 2'h3;
        default: rot_amt = 2'h0;
      endcase
    end
  endfunction

  function is_gfx;
    input [3:0] b;
    begin
      is_gfx = (b == 4'h2) || (b == 4'h3) || (b == 4'hb) || (b == 4'hc);
    end
  endfunction

  wire brg_idx = (reg_addr >= `IDX_BRG_FIRST && reg_addr <= `IDX_BRG_LAST && reg_addr[0]) ||
                 (reg_addr == `IDX_BRG13_CNTL);
  wire [3:0] wr_slot = (reg_addr == `IDX_BRG13_CNTL) ? 4'ha :
                       reg_addr[4:1] - 4'h8;
  wire [1:0] p2p_mode = feat_q[`BIT_P2P_MODE_LO+1:`BIT_P2P_MODE_LO];
  wire wr_nb = reg_wr && (reg_addr == `IDX_NB_CNTL);
  wire wr_misc12 = reg_wr && (reg_addr == `IDX_MISC_12);
  wire wr_rid = reg_wr && (reg_addr == `IDX_PCIE_RID);
  wire wr_feat = reg_wr && (reg_addr == `IDX_FEATURE);
  wire wr_clk = reg_wr && (reg_addr == `IDX_CLK_CFG);
  wire wr_alt = reg_wr && (reg_addr == `IDX_BRG_INT);
  wire wr_dis = reg_wr && brg_idx;
  reg [31:0] reg_rdata_d;

  // zero byte enable pass-through control
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nb_cntl_q <= 32'h0;
    end else if (wr_nb) begin
      nb_cntl_q <= reg_wdata;
    end
  end

  // interrupt mode and requester id enables
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      misc12_q <= 32'h0;
    end else if (wr_misc12) begin
      misc12_q <= reg_wdata;
    end
  end

  // core requester id enable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rid_q <= 32'h0;
    end else if (wr_rid) begin
      rid_q <= reg_wdata;
    end
  end

  // access enables, error fields, peer mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feat_q <= `RST_FEATURE;
    end else begin
      if (wr_feat)
        feat_q <= reg_wdata;
      if (secure_init) begin
        feat_q[`BIT_JTAG_EN] <= 1'b0;
        feat_q[`BIT_MCU_EN] <= 1'b0;
      end
    end
  end

  // branch gate disables
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= `RST_CLK_CFG;
    end else if (wr_clk) begin
      clk_q <= reg_wdata;
    end
  end

  // alternate interrupt group select, one bit per bridge number
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_interrupt_group_select_q <= 16'h0;
    end else if (wr_alt) begin
      alt_interrupt_group_select_q <= reg_wdata[15:0];
    end
  end

  // per bridge peer path disable, all paths open at power-up
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p2p_dis_q <= {NUM_BRG{1'b0}};
    end else if (wr_dis) begin
      p2p_dis_q[wr_slot] <= reg_wdata[`BIT_P2P_DIS];
    end
  end

  // read data stands one cycle after the strobe, else zero
  always @* begin
    reg_rdata_d = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `IDX_NB_CNTL: reg_rdata_d = nb_cntl_q;
        `IDX_MISC_12: reg_rdata_d = misc12_q;
        `IDX_PCIE_RID: reg_rdata_d = rid_q;
        `IDX_FEATURE: reg_rdata_d = feat_q;
        `IDX_CLK_CFG: reg_rdata_d = clk_q;
        `IDX_BRG_INT: reg_rdata_d = {16'h0, alt_interrupt_group_select_q};
        default: begin
          if (brg_idx)
            reg_rdata_d = {28'h0, p2p_dis_q[wr_slot], 3'h0};
        end
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rdata_d;
    end
  end

  // side-path gating, request decoding, interrupt remap
  reg dbg_accept_d;
  reg dbg_complete_d;
  reg dbg_rd_ones_d;
  reg mcu_accept_d;
  reg mcu_complete_d;
  reg mcu_rd_ones_d;
  reg p2p_fwd_peer_d;
  reg p2p_fwd_host_d;
  reg p2p_drop_d;
  reg p2p_fwd_rid_d;
  reg [15:0] host_be_d;
  reg err_return_d;
  reg master_branch_clk_en_d;
  reg slave_branch_clk_en_d;
  reg [7:0] int_out_d;
  reg [3:0] s_src;
  reg [3:0] s_tgt;
  reg src_ok;
  reg tgt_ok;
  reg [2:0] aer_field;
  wire [1:0] r = rot_amt(int_brg);
  wire [3:0] rot;
  wire dbg_en = feat_q[`BIT_JTAG_EN];
  wire mcu_en = feat_q[`BIT_MCU_EN];
  wire remap_on = nb_irq_ctrl_dis && (brg_slot(int_brg) != 4'hf);

  // output pin j takes input pin j minus the rotation
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : rot_g
      localparam [1:0] pin_no = g;
      wire [1:0] src_pin = pin_no - r;
      assign rot[g] = int_in[src_pin];
    end
  endgenerate

  // disabled path: posted writes vanish, non-posted commit, reads ones
  always @* begin
    dbg_accept_d = dbg_req && dbg_en;
    dbg_complete_d = dbg_req && !(dbg_write && dbg_posted);
    dbg_rd_ones_d = dbg_req && !dbg_write && !dbg_en;
    mcu_accept_d = mcu_req && mcu_en;
    mcu_complete_d = mcu_req && !(mcu_write && mcu_posted);
    mcu_rd_ones_d = mcu_req && !mcu_write && !mcu_en;
  end

  // peer request routing by mode, type and path enables
  always @* begin
    s_src = brg_slot(p2p_src_brg);
    s_tgt = brg_slot(p2p_tgt_brg);
    src_ok = p2p_src_sb || (s_src != 4'hf && !p2p_dis_q[s_src]);
    tgt_ok = p2p_tgt_sb ? (p2p_mode == 2'h1 || p2p_mode == 2'h2) :
             (s_tgt != 4'hf && !p2p_dis_q[s_tgt]);
    p2p_fwd_peer_d = 1'b0;
    p2p_fwd_host_d = 1'b0;
    p2p_drop_d = 1'b0;
    p2p_fwd_rid_d = 1'b0;
    if (p2p_req) begin
      if (!p2p_is_mem_wr || !src_ok) begin
        p2p_drop_d = 1'b1;
      end else if (p2p_mode == `P2P_MODE_ALL) begin
        p2p_fwd_host_d = 1'b1;
      end else if (p2p_tgt_sb) begin
        if (tgt_ok)
          p2p_fwd_host_d = 1'b1;
        else
          p2p_drop_d = 1'b1;
      end else if (p2p_hit && tgt_ok) begin
        p2p_fwd_peer_d = 1'b1;
        p2p_fwd_rid_d = is_gfx(p2p_tgt_brg) ? misc12_q[`BIT_RID_GFX] :
                        misc12_q[`BIT_RID_GPP];
      end else if (!p2p_hit && p2p_mode == 2'h1) begin
        p2p_fwd_host_d = 1'b1;
      end else begin
        p2p_drop_d = 1'b1;
      end
    end
  end

  // error return when the core's field holds four
  always @* begin
    aer_field = 3'h0;
    if (err_core < 3'h5)
      aer_field = feat_q[`BIT_AER_LO+3*err_core+:3];
    err_return_d = err_valid && (aer_field == `AER_FIELD_ON);
  end

  // zero byte enables widen to all lanes unless pass-through is set
  always @* begin
    if (nb_cntl_q[`BIT_ZERO_BE])
      host_be_d = dma_be;
    else if (dma_be == 16'h0)
      host_be_d = 16'hffff;
    else
      host_be_d = dma_be;
    // dynamic gating only on branches; 1 keeps branch running
    master_branch_clk_en_d = clk_q[`BIT_MST_GATE_DIS] || !mst_idle;
    slave_branch_clk_en_d = clk_q[`BIT_SLV_GATE_DIS] || !slv_idle;
  end

  // legacy pins remap only with southbridge routing
  always @* begin
    if (!remap_on)
      int_out_d = {4'h0, int_in};
    else if (alt_interrupt_group_select_q[int_brg])
      int_out_d = {rot, 4'h0};
    else
      int_out_d = {4'h0, rot};
  end

  // every output leaves a flip-flop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_accept <= 1'b0;
      dbg_complete <= 1'b0;
      dbg_rd_ones <= 1'b0;
      mcu_accept <= 1'b0;
      mcu_complete <= 1'b0;
      mcu_rd_ones <= 1'b0;
      p2p_fwd_peer <= 1'b0;
      p2p_fwd_host <= 1'b0;
      p2p_drop <= 1'b0;
      p2p_fwd_rid <= 1'b0;
      pcie_rid_fwd_en <= 1'b0;
      host_be <= 16'h0;
      err_return <= 1'b0;
      edge_level_en <= 1'b0;
      master_branch_clk_en <= 1'b1;
      slave_branch_clk_en <= 1'b1;
      int_out <= 8'h0;
    end else begin
      dbg_accept <= dbg_accept_d;
      dbg_complete <= dbg_complete_d;
      dbg_rd_ones <= dbg_rd_ones_d;
      mcu_accept <= mcu_accept_d;
      mcu_complete <= mcu_complete_d;
      mcu_rd_ones <= mcu_rd_ones_d;
      p2p_fwd_peer <= p2p_fwd_peer_d;
      p2p_fwd_host <= p2p_fwd_host_d;
      p2p_drop <= p2p_drop_d;
      p2p_fwd_rid <= p2p_fwd_rid_d;
      pcie_rid_fwd_en <= rid_q[`BIT_RID_PCIE];
      host_be <= host_be_d;
      err_return <= err_return_d;
      edge_level_en <= misc12_q[`BIT_EDGE_LEVEL];
      master_branch_clk_en <= master_branch_clk_en_d;
      slave_branch_clk_en <= slave_branch_clk_en_d;
      int_out <= int_out_d;
    end
  end
endmodule

//--- test/fg_monitor.sv
`timescale 1ns/10ps
module fg_monitor (
  input wire clk, rst_n, secure_init, reg_rd,
  input wire dbg_req, dbg_write, dbg_posted, dbg_accept, dbg_complete, dbg_rd_ones,
  input wire mcu_req, mcu_write, mcu_accept, mcu_rd_ones,
  input wire p2p_req, p2p_is_mem_wr, p2p_fwd_peer, p2p_fwd_host, p2p_drop,
  input wire mst_idle, slv_idle, master_branch_clk_en, slave_branch_clk_en, nb_irq_ctrl_dis,
  input wire [31:0] reg_rdata,
  input wire [3:0] int_in,
  input wire [7:0] int_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_dbg_ones;
    secure_init ##1 (dbg_req && !dbg_write) |=> dbg_rd_ones && !dbg_accept;
  endproperty
  a_dbg_ones: assert property (p_dbg_ones) else $error("debug read not ones");
  property p_dbg_drop;
    secure_init ##1 (dbg_req && dbg_write && dbg_posted) |=> !dbg_accept && !dbg_complete;
  endproperty
  a_dbg_drop: assert property (p_dbg_drop) else $error("debug write not dropped");
  property p_mcu_ones;
    secure_init ##1 (mcu_req && !mcu_write) |=> mcu_rd_ones && !mcu_accept;
  endproperty
  a_mcu_ones: assert property (p_mcu_ones) else $error("mcu read not ones");
  property p_p2p_type;
    p2p_req && !p2p_is_mem_wr |=> p2p_drop && !p2p_fwd_peer && !p2p_fwd_host;
  endproperty
  a_p2p_type: assert property (p_p2p_type) else $error("non write carried");
  property p_p2p_one; $onehot0({p2p_fwd_peer, p2p_fwd_host, p2p_drop}); endproperty
  a_p2p_one: assert property (p_p2p_one) else $error("two p2p outcomes");
  property p_mst_busy; !mst_idle |=> master_branch_clk_en; endproperty
  a_mst_busy: assert property (p_mst_busy) else $error("busy master gated");
  property p_slv_busy; !slv_idle |=> slave_branch_clk_en; endproperty
  a_slv_busy: assert property (p_slv_busy) else $error("busy slave gated");
  property p_int_pass; !nb_irq_ctrl_dis |=> int_out[3:0] == $past(int_in); endproperty
  a_int_pass: assert property (p_int_pass) else $error("pins remapped");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  c_ones: cover property (dbg_rd_ones);
  c_host: cover property (p2p_fwd_host);
  c_alt: cover property (|int_out[7:4]);
endmodule
bind io_ctrl_feature_gating fg_monitor mon_u (.*);

//--- test/brg_model.sv
`timescale 1ns/10ps
module brg_model (
  input wire clk,
  input wire rst_n,
  input wire zero_be,
  output reg [3:0] int_in = 4'h0,
  output reg [15:0] dma_be = 16'h0
);
  // bridges toggle legacy pins freely and send random dma byte enables, all zero while zero_be is set
  always @(posedge clk) begin
    if (rst_n) begin
      int_in <= 4'($urandom);
      dma_be <= zero_be ? 16'h0 : 16'($urandom);
    end
  end
endmodule

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, secure_init = 0, zero_be = 0, zb = 0;
  logic dbg_req = 0, dbg_write = 0, dbg_posted = 0, mcu_req = 0, mcu_write = 0, mcu_posted = 0;
  logic p2p_req = 0, p2p_src_sb = 0, p2p_is_mem_wr = 0, p2p_hit = 0, p2p_tgt_sb = 0;
  logic err_valid = 0, mst_idle = 1, slv_idle = 1, nb_irq_ctrl_dis = 0;
  logic [3:0] p2p_src_brg = 4'h0, p2p_tgt_brg = 4'h0, int_brg = 4'h0, int_in;
  logic [2:0] err_core = 3'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [15:0] dma_be, alt = 16'h0;
  wire [31:0] reg_rdata;
  wire [15:0] host_be;
  wire [7:0] int_out;
  wire dbg_accept, dbg_complete, dbg_rd_ones, mcu_accept, mcu_complete, mcu_rd_ones;
  wire p2p_fwd_peer, p2p_fwd_host, p2p_drop, p2p_fwd_rid, pcie_rid_fwd_en, err_return;
  wire edge_level_en, master_branch_clk_en, slave_branch_clk_en;
  int miscompares = 0, n_tests = 0;
  always #25 clk = ~clk;
  io_ctrl_feature_gating dut_u (.*);
  brg_model far_u (.*);
  task automatic chk(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input [7:0] a, input [31:0] e);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 0;
    @(negedge clk);
    chk(reg_rdata, e);
    @(posedge clk);
  endtask
  task automatic req(input m, w, p, input [2:0] e);
    {dbg_req, mcu_req, dbg_write, dbg_posted, mcu_write, mcu_posted} <= {!m, m, w, p, w, p};
    @(posedge clk);
    {dbg_req, mcu_req} <= 2'h0;
    @(negedge clk);
    chk(m ? {mcu_accept, mcu_complete, mcu_rd_ones} : {dbg_accept, dbg_complete, dbg_rd_ones}, e);
    @(posedge clk);
  endtask
  task automatic acc_all(input en);
    for (int k = 0; k < 6; k++)
      req(k[0], k > 1, k > 3, {en, !(k > 3), !en && k < 2});
  endtask
  task automatic p2p(input [3:0] s, input mw, h, tsb, input [3:0] t, input [3:0] e);
    {p2p_req, p2p_src_brg, p2p_is_mem_wr, p2p_hit, p2p_tgt_sb, p2p_tgt_brg} <= {1'b1, s, mw, h, tsb, t};
    @(posedge clk);
    p2p_req <= 0;
    @(negedge clk);
    chk({p2p_fwd_peer, p2p_fwd_host, p2p_drop, p2p_fwd_rid}, e);
    @(posedge clk);
  endtask
  task automatic err(input [2:0] c, input e);
    {err_valid, err_core} <= {1'b1, c};
    @(posedge clk);
    err_valid <= 0;
    @(negedge clk);
    chk(err_return, e);
    @(posedge clk);
  endtask
  function automatic [7:0] rot(input [3:0] b, input a, input [3:0] i);
    logic [7:0] x;
    x = {i, i} >> (4 - ((b == 4 || b == 12) ? 0 : (b == 5 || b == 9 || b == 13) ? 1 :
      (b == 2 || b == 6 || b == 10) ? 2 : 3));
    return a ? {x[3:0], 4'h0} : {4'h0, x[3:0]};
  endfunction
  task automatic watch(input int n);
    logic [3:0] li;
    logic [15:0] lb;
    repeat (2) @(posedge clk);
    @(negedge clk);
    {li, lb} = {int_in, dma_be};
    repeat (n) begin
      @(negedge clk);
      chk(int_out, nb_irq_ctrl_dis ? rot(int_brg, alt[int_brg], li) : {4'h0, li});
      chk(host_be, (lb == 16'h0 && !zb) ? 16'hffff : lb);
      {li, lb} = {int_in, dma_be};
    end
    @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    give_verdict();
  end
  initial begin
    void'($urandom(39));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(8'h75, 32'h1800);
    rd(8'h8c, 32'h6000);
    rd(8'h12, 32'h0);
    rd(8'h6a, 32'h0);
    rd(8'h00, 32'h0);
    $display("reset test done");
    acc_all(1);
    secure_init <= 1;
    wr(8'h75, 32'h1800);
    secure_init <= 0;
    rd(8'h75, 32'h0);
    acc_all(0);
    wr(8'h75, 32'h1800);
    acc_all(1);
    $display("access test done");
    p2p(4, 1, 1, 0, 5, 4'b1000);
    p2p(4, 0, 1, 0, 5, 4'b0010);
    p2p(4, 1, 0, 0, 5, 4'b0010);
    p2p(9, 1, 1, 1, 0, 4'b0010);
    wr(8'h12, 32'h0009_0000);
    wr(8'h6a, 32'h8);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({edge_level_en, pcie_rid_fwd_en}, 2'h3);
    @(posedge clk);
    p2p(5, 1, 1, 0, 2, 4'b1001);
    p2p(5, 1, 1, 0, 6, 4'b1000);
    wr(8'h75, 32'h9c00);
    err(0, 1);
    err(1, 0);
    p2p(4, 1, 1, 0, 5, 4'b0100);
    p2p(9, 1, 1, 1, 0, 4'b0100);
    wr(8'h51, 32'h8);
    p2p(2, 1, 1, 0, 5, 4'b0010);
    wr(8'h75, 32'h1a00);
    p2p(4, 1, 0, 0, 5, 4'b0100);
    p2p(9, 1, 1, 1, 0, 4'b0100);
    p2p(4, 1, 1, 0, 2, 4'b0010);
    $display("p2p test done");
    wr(8'h8c, 32'h0);
    repeat (4) begin
      {mst_idle, slv_idle} <= 2'($urandom);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({master_branch_clk_en, slave_branch_clk_en}, {!mst_idle, !slv_idle});
      @(posedge clk);
    end
    alt = 16'($urandom);
    wr(8'h90, {16'h0, alt});
    zero_be <= 1;
    watch(6);
    nb_irq_ctrl_dis <= 1;
    for (int b = 2; b < 14; b++)
      if (b != 8) begin
        int_brg <= 4'(b);
        zero_be <= b[0];
        watch(4);
      end
    wr(8'h01, 32'h100);
    zb = 1;
    watch(4);
    $display("pin test done");
    give_verdict();
  end
endmodule
